// ===== common/bfsp_pkg.sv
// types for the boot flash self-program sequencer
// assumes the constants header is on the include path
package bfsp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bfsp_bus_t;
  typedef struct packed {
    logic valid;
    logic [15:0] pc;
    logic [15:0] z;
    logic [15:0] data;
  } bfsp_store_t;
  typedef enum logic [3:0] {
    BFSP_IDLE = 4'b0001,
    BFSP_ERASE = 4'b0010,
    BFSP_WRITE = 4'b0100,
    BFSP_LOCK = 4'b1000
  } bfsp_state_t;
endpackage

// ===== common/bfsp_regs.svh
// constants for the boot flash self-program sequencer
// assumes inclusion by bare name from the sequencer core and test files
`ifndef BFSP_REGS_SVH
`define BFSP_REGS_SVH
`define BFSP_CTRL_OFF 8'h00
`define BFSP_STAT_OFF 8'h01
`define BFSP_MASK_OFF 8'h02
`define BFSP_LOCK_OFF 8'h03
`define BFSP_CTRL_RST 8'h00
`define BFSP_CMD_ERASE 5'h03
`define BFSP_CMD_LOAD 5'h01
`define BFSP_CMD_WRITE 5'h05
`define BFSP_CMD_LOCK 5'h09
`define BFSP_CMD_MASK 5'h1F
`define BFSP_EN_BIT 0
`define BFSP_STORE_WIN 3'h4
`define BFSP_LOAD_WIN 3'h5
`define BFSP_PAGES 256
`define BFSP_PAGE_WORDS 64
`define BFSP_BOOT_256 14'h3F00
`define BFSP_BOOT_512 14'h3E00
`define BFSP_BOOT_1K 14'h3C00
`define BFSP_BOOT_2K 14'h3800
`define BFSP_APP_RESET 14'h0000
`define BFSP_ERASE_NS 4000
`define BFSP_CLK_NS 10
`define BFSP_ERASE_CYC ((`BFSP_ERASE_NS + `BFSP_CLK_NS - 1) / `BFSP_CLK_NS)
`define BFSP_LOCK_RST 8'hFF
`endif

// ===== core/bfsp_page_buf.sv
// temporary page buffer, one word per slot
// assumes writes and reads on the single core clock
`timescale 1ns/10ps
module bfsp_page_buf import bfsp_pkg::*; #(
  parameter int WORDS = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_slot,
  input wire logic [15:0] wr_data,
  input wire logic [$clog2(WORDS)-1:0] rd_slot,
  output logic [15:0] rd_data
);
  logic [15:0] mem [WORDS];
  // any slot in any order
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= 16'hFFFF;
      end
    end else if (wr_en) begin
      mem[wr_slot] <= wr_data; // RL10
    end
  end
  assign rd_data = mem[rd_slot];
endmodule // bfsp_page_buf

// ===== core/bfsp_seq.sv
// boot flash self-program sequencer with flash array and register port
// assumes a cpu core on the same clock issuing store and load strobes
//
// Contract
// (RL1) flash is 256 pages of 64 words
// (RL2) boot size fuses set boot start address
// (RL3) store acts only when fetched from boot
// (RL4) boot reset fuse picks reset vector
// (RL5) cpu cannot change any fuse
// (RL6) general lock bits never gate self-programming
// (RL7) 00011 arms page erase of pointer page
// (RL8) 00001 loads word into buffer slot
// (RL9) 00101 copies buffer into pointer page
// (RL10) buffer slots load in any order
// (RL11) software erases before write, same page
// (RL12) cpu halted, enable cleared on completion
// (RL13) software keeps interrupts off while programming
// (RL14) boot code may program any location
// (RL15) separate lock bits per section
// (RL16) software should protect boot section
// (RL17) armed enable clears after four/five cycles
// (RL18) stray stores leave flash untouched
// (RL19) window opens at control write, one store
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "bfsp_regs.svh"
module bfsp_seq import bfsp_pkg::*; #(
  parameter int PAGES = `BFSP_PAGES,
  parameter int WORDS = `BFSP_PAGE_WORDS,
  parameter int ERASE_CYC = `BFSP_ERASE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire bfsp_bus_t bus,
  output logic [7:0] rdata,
  input wire bfsp_store_t store,
  input wire logic load_valid,
  input wire logic [15:0] fetch_addr,
  output logic [15:0] fetch_data,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_select_fuse,
  output logic [13:0] reset_vector,
  output logic cpu_halt,
  output logic irq
);
  localparam int AW = $clog2(PAGES * WORDS);
  localparam int SW = $clog2(WORDS);
  logic [15:0] flash [PAGES * WORDS];
  logic [7:0] self_program_control_reg;
  logic [7:0] lock_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [2:0] win_reg;
  logic [15:0] cnt_reg;
  logic [7:0] page_reg;
  logic [SW-1:0] copy_reg;
  bfsp_state_t state_reg;
  logic [1:0] fuse_s1, fuse_s2;
  logic rst_s1, rst_s2;
  logic [15:0] buf_rd;
  logic arm_store, in_boot, tgt_boot, blocked, take, done;
  logic [4:0] cmd;
  logic [13:0] boot_start;

  function automatic logic [13:0] boot_base(input logic [1:0] sz);
    unique case (sz)
      2'b11: boot_base = `BFSP_BOOT_256; // RL2
      2'b10: boot_base = `BFSP_BOOT_512;
      2'b01: boot_base = `BFSP_BOOT_1K;
      default: boot_base = `BFSP_BOOT_2K;
    endcase
  endfunction

  // fuses are pins only, double-sampled; no cpu write path exists
  always_ff @(posedge clk) begin
    fuse_s1 <= boot_size_fuses; // RL5
    fuse_s2 <= fuse_s1;
    rst_s1 <= boot_reset_select_fuse;
    rst_s2 <= rst_s1;
  end
  assign boot_start = boot_base(fuse_s2);
  assign cmd = self_program_control_reg[4:0];
  assign in_boot = store.pc[13:0] >= boot_start; // RL3
  assign tgt_boot = store.z[14:1] >= boot_start;
  // only boot lock bits matter, the general ones are not consulted
  assign blocked = tgt_boot ? !lock_reg[4] : !lock_reg[2]; // RL6 RL15
  assign arm_store = win_reg != 3'h0 && self_program_control_reg[`BFSP_EN_BIT];
  assign take = store.valid && in_boot && arm_store && state_reg == BFSP_IDLE; // RL18
  assign done = state_reg != BFSP_IDLE && cnt_reg == 16'h0000
                && (state_reg != BFSP_WRITE || copy_reg == SW'(WORDS - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reset_vector <= `BFSP_APP_RESET;
    end else begin
      reset_vector <= rst_s2 ? boot_start : `BFSP_APP_RESET; // RL4
    end
  end

  // control register, arming window and auto clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      self_program_control_reg <= `BFSP_CTRL_RST;
      win_reg <= 3'h0;
    end else if (bus.wr && bus.addr == `BFSP_CTRL_OFF && state_reg == BFSP_IDLE) begin
      self_program_control_reg <= bus.wdata;
      win_reg <= (bus.wdata[4:0] == `BFSP_CMD_LOCK) ? `BFSP_LOAD_WIN : `BFSP_STORE_WIN; // RL19
    end else if (take) begin
      win_reg <= 3'h0; // RL19
      if (!(cmd == `BFSP_CMD_ERASE || cmd == `BFSP_CMD_WRITE) || blocked) begin
        self_program_control_reg <= `BFSP_CTRL_RST; // RL12
      end
    end else if (done) begin
      self_program_control_reg <= `BFSP_CTRL_RST; // RL12
    end else if (load_valid && cmd == `BFSP_CMD_LOCK && win_reg != 3'h0) begin
      self_program_control_reg <= `BFSP_CTRL_RST;
      win_reg <= 3'h0;
    end else if (win_reg != 3'h0) begin
      win_reg <= win_reg - 3'h1;
      if (win_reg == 3'h1 && state_reg == BFSP_IDLE) begin
        self_program_control_reg <= `BFSP_CTRL_RST; // RL17
      end
    end
  end

  // sequencer: erase or write timed, cpu halted meanwhile
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= BFSP_IDLE;
      cnt_reg <= 16'h0000;
      page_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        BFSP_IDLE: begin
          if (take && cmd == `BFSP_CMD_LOCK) begin
            state_reg <= BFSP_LOCK;
            cnt_reg <= 16'h0000;
          end else if (take && !blocked) begin // RL14
            page_reg <= store.z[14:7]; // RL7 RL9
            cnt_reg <= 16'(ERASE_CYC - 1);
            if (cmd == `BFSP_CMD_ERASE) begin
              state_reg <= BFSP_ERASE;
            end else if (cmd == `BFSP_CMD_WRITE) begin
              state_reg <= BFSP_WRITE;
            end
          end
        end
        BFSP_ERASE, BFSP_WRITE, BFSP_LOCK: begin
          if (done) begin
            state_reg <= BFSP_IDLE;
          end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // page write copies one buffer slot per cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      copy_reg <= '0;
    end else if (state_reg == BFSP_WRITE && cnt_reg == 16'h0000) begin
      copy_reg <= copy_reg + SW'(1);
    end
  end

  // flash array, whole-page erase and page copy only
  always_ff @(posedge clk) begin
    if (state_reg == BFSP_ERASE && cnt_reg == 16'h0000) begin
      for (int i = 0; i < WORDS; i++) begin
        flash[{page_reg, SW'(i)}] <= 16'hFFFF; // RL1 RL7
      end
    end else if (state_reg == BFSP_WRITE && cnt_reg == 16'h0000) begin
      flash[{page_reg, copy_reg}] <= buf_rd; // RL9 RL11
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fetch_data <= 16'hFFFF;
    end else begin
      fetch_data <= flash[fetch_addr[AW-1:0]];
    end
  end

  // lock bits: only boot lock fields are writable, ones-to-zero only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lock_reg <= `BFSP_LOCK_RST;
    end else if (take && cmd == `BFSP_CMD_LOCK) begin
      lock_reg <= lock_reg & (store.data[7:0] | 8'hC3); // RL15
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_halt <= 1'b0;
    end else begin
      cpu_halt <= (take && (cmd == `BFSP_CMD_LOCK
                  || ((cmd == `BFSP_CMD_ERASE || cmd == `BFSP_CMD_WRITE) && !blocked)))
                  || (state_reg != BFSP_IDLE && !done); // RL12
    end
  end

  bfsp_page_buf #(.WORDS(WORDS)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(take && cmd == `BFSP_CMD_LOAD), // RL8
    .wr_slot(store.z[SW:1]),
    .wr_data(store.data),
    .rd_slot(copy_reg),
    .rd_data(buf_rd)
  );

  // status: bit0 done, bit1 refused store; set wins over read clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_reg <= 2'b00;
      mask_reg <= 2'b00;
    end else begin
      stat_reg <= ((bus.rd && bus.addr == `BFSP_STAT_OFF) ? 2'b00 : stat_reg)
                  | {store.valid && !take, done};
      if (bus.wr && bus.addr == `BFSP_MASK_OFF) begin
        mask_reg <= bus.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
      rdata <= 8'h00;
    end else begin
      irq <= |(stat_reg & mask_reg);
      if (bus.rd) begin
        unique case (bus.addr)
          `BFSP_CTRL_OFF: rdata <= self_program_control_reg;
          `BFSP_STAT_OFF: rdata <= {6'h00, stat_reg};
          `BFSP_MASK_OFF: rdata <= {6'h00, mask_reg};
          `BFSP_LOCK_OFF: rdata <= lock_reg;
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  a_window_close: assert property (@(posedge clk) disable iff (!rst_b)
    take |=> win_reg == 3'h0) else $error("window stays open after store"); // RL19
  a_stray_store: assert property (@(posedge clk) disable iff (!rst_b)
    store.valid && !in_boot |=> state_reg == BFSP_IDLE) else $error("application store acted"); // RL3
  a_arm_expire: assert property (@(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr == `BFSP_CTRL_OFF && bus.wdata[4:0] == `BFSP_CMD_ERASE && state_reg == BFSP_IDLE
    ##1 (!store.valid && !bus.wr) [*4] |=> !self_program_control_reg[0]) else $error("arm not expired"); // RL17
  a_halt_busy: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == BFSP_ERASE && !done |=> cpu_halt) else $error("cpu not halted"); // RL12
  a_erase_len: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_reg == BFSP_ERASE) |-> ##[1:1000] state_reg == BFSP_IDLE) else $error("erase too long"); // RL7
  a_reset_vec: assert property (@(posedge clk) disable iff (!rst_b)
    !rst_s2 |=> reset_vector == `BFSP_APP_RESET) else $error("reset vector not app"); // RL4
  a_boot_base: assert property (@(posedge clk) disable iff (!rst_b)
    fuse_s2 == 2'b10 |-> boot_start == `BFSP_BOOT_512) else $error("boot start wrong"); // RL2
  a_load_clear: assert property (@(posedge clk) disable iff (!rst_b)
    take && cmd == `BFSP_CMD_LOAD |=> self_program_control_reg == 8'h00) else $error("load left enable"); // RL8
endmodule // bfsp_seq

// ===== test/bfsp_cpu_model.sv
// cpu core model: register port, store strobe and fetch port
// assumes the sequencer on the same clock, sampling at rising edges
`timescale 1ns/10ps
`include "bfsp_regs.svh"
module bfsp_cpu_model import bfsp_pkg::*; (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic [15:0] fetch_data,
  output bfsp_bus_t bus,
  output bfsp_store_t store,
  output logic load_valid,
  output logic [15:0] fetch_addr
);
  initial begin
    bus = '0;
    store = '0;
    load_valid = 1'b0;
    fetch_addr = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // arm, then store after gap extra cycles; gap 0 stays inside the window
  task automatic cmd(input logic [4:0] c, input logic [15:0] pc, input logic [15:0] z, input logic [15:0] d,
                     input int gap);
    wr(`BFSP_CTRL_OFF, {3'b000, c});
    repeat (gap) @(posedge clk);
    @(posedge clk);
    store <= '{1'b1, pc, z, d};
    @(posedge clk);
    store.valid <= 1'b0;
  endtask
  // interrupts stay off here: the model issues no other traffic meanwhile
  task automatic poll(output bit ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      rd(`BFSP_CTRL_OFF, v);
      ok = (v[`BFSP_EN_BIT] === 1'b0);
    end
  endtask
  task automatic peek(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    fetch_addr <= a;
    @(posedge clk);
    #1 d = fetch_data;
  endtask
endmodule // bfsp_cpu_model

// ===== test/boot_flash_self_program_tb_top.sv
// self-checking bench for the boot flash self-program sequencer
// assumes the cpu model drives the bus, store and fetch ports
`timescale 1ns/10ps
`include "bfsp_regs.svh"
module boot_flash_self_program_tb_top import bfsp_pkg::*; ;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bfsp_bus_t bus;
  bfsp_store_t store;
  logic load_valid;
  logic [15:0] fetch_addr;
  logic [15:0] fetch_data;
  logic [7:0] rdata;
  logic [1:0] boot_size_fuses = 2'b11;
  logic boot_reset_select_fuse = 1'b1;
  logic [13:0] reset_vector;
  logic cpu_halt;
  logic irq;
  logic [7:0] v;
  int failures = 0;
  int compares = 0;
  logic [16:0] rows [5] = '{{3'b111, `BFSP_BOOT_256}, {3'b101, `BFSP_BOOT_512}, {3'b011, `BFSP_BOOT_1K},
                            {3'b001, `BFSP_BOOT_2K}, {3'b000, `BFSP_APP_RESET}};
  `define chk(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, a); end end
  always #5 clk = ~clk;
  bfsp_seq #(.ERASE_CYC(4)) dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .store(store),
    .load_valid(load_valid), .fetch_addr(fetch_addr), .fetch_data(fetch_data), .boot_size_fuses(boot_size_fuses),
    .boot_reset_select_fuse(boot_reset_select_fuse), .reset_vector(reset_vector), .cpu_halt(cpu_halt), .irq(irq));
  bfsp_cpu_model cpu (.clk(clk), .rdata(rdata), .fetch_data(fetch_data), .bus(bus), .store(store),
    .load_valid(load_valid), .fetch_addr(fetch_addr));
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watches for the halt, then polls the enable bit with a bound
  task automatic finish_op(input bit busy);
    bit seen;
    bit ok;
    seen = 1'b0;
    repeat (4) begin
      #1 seen |= (cpu_halt === 1'b1);
      @(posedge clk);
    end
    cpu.poll(ok);
    `chk("cpu_halt seen", busy, seen)
    `chk("enable cleared", 1'b1, ok)
    if (!ok) report_and_stop();
  endtask
  task automatic word_is(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    cpu.peek(a, d);
    `chk("flash word", e, d)
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
    cpu.rd(a, v);
    `chk("register", e, v)
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1 `chk("cpu_halt", 1'b0, cpu_halt)
    `chk("irq", 1'b0, irq)
    reg_is(`BFSP_CTRL_OFF, `BFSP_CTRL_RST);
    reg_is(`BFSP_LOCK_OFF, `BFSP_LOCK_RST);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {boot_size_fuses, boot_reset_select_fuse} <= rows[i][16:14];
      repeat (5) @(posedge clk);
      #1 `chk("reset_vector", rows[i][13:0], reset_vector)
    end
    @(posedge clk);
    {boot_size_fuses, boot_reset_select_fuse} <= 3'b111;
    repeat (5) @(posedge clk);
    $display("test fuses done");
    cpu.cmd(`BFSP_CMD_ERASE, 16'h3F00, 16'h027F, 16'h1234, 0);
    finish_op(1'b1);
    word_is(16'h0100, 16'hFFFF);
    word_is(16'h013F, 16'hFFFF);
    reg_is(`BFSP_STAT_OFF, 8'h01);
    cpu.cmd(`BFSP_CMD_LOAD, 16'h3F10, 16'h020A, 16'hA5A5, 0);
    finish_op(1'b0);
    cpu.cmd(`BFSP_CMD_LOAD, 16'h3F10, 16'h0204, 16'h5A5A, 0);
    finish_op(1'b0);
    cpu.cmd(`BFSP_CMD_WRITE, 16'h3F00, 16'h0200, 16'h0000, 0);
    finish_op(1'b1);
    word_is(16'h0105, 16'hA5A5);
    word_is(16'h0102, 16'h5A5A);
    word_is(16'h0100, 16'hFFFF);
    $display("test program done");
    reg_is(`BFSP_STAT_OFF, 8'h01);
    cpu.wr(`BFSP_MASK_OFF, 8'h02);
    cpu.cmd(`BFSP_CMD_ERASE, 16'h0100, 16'h0200, 16'h0000, 0);
    finish_op(1'b0);
    word_is(16'h0105, 16'hA5A5);
    #1 `chk("irq", 1'b1, irq)
    reg_is(`BFSP_STAT_OFF, 8'h02);
    @(posedge clk);
    #1 `chk("irq", 1'b0, irq)
    cpu.cmd(`BFSP_CMD_ERASE, 16'h3F00, 16'h0200, 16'h0000, 5);
    finish_op(1'b0);
    word_is(16'h0105, 16'hA5A5);
    $display("test refusals done");
    cpu.cmd(`BFSP_CMD_ERASE, 16'h3F00, 16'h7E00, 16'h0000, 0);
    finish_op(1'b1);
    word_is(16'h3F00, 16'hFFFF);
    $display("test boot erase done");
    cpu.cmd(`BFSP_CMD_LOCK, 16'h3F00, 16'h0001, 16'h00EF, 0);
    finish_op(1'b1);
    reg_is(`BFSP_LOCK_OFF, 8'hEF);
    cpu.cmd(`BFSP_CMD_LOAD, 16'h3F00, 16'h7E00, 16'h1234, 0);
    finish_op(1'b0);
    cpu.cmd(`BFSP_CMD_WRITE, 16'h3F00, 16'h7E00, 16'h0000, 0);
    finish_op(1'b0);
    word_is(16'h3F00, 16'hFFFF);
    cpu.cmd(`BFSP_CMD_ERASE, 16'h3F00, 16'h0200, 16'h0000, 0);
    finish_op(1'b1);
    word_is(16'h0105, 16'hFFFF);
    $display("test lock done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 `chk("cpu_halt", 1'b0, cpu_halt)
    `chk("irq", 1'b0, irq)
    reg_is(`BFSP_CTRL_OFF, `BFSP_CTRL_RST);
    reg_is(`BFSP_LOCK_OFF, `BFSP_LOCK_RST);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule // boot_flash_self_program_tb_top
